// File: rtl/mtxr_pkg.sv
package mtxr_pkg;

  localparam logic [7:0] ADDR_ALIGN = 8'h23;
  localparam logic [7:0] ADDR_TXRES = 8'h24;
  localparam logic [7:0] ADDR_BCON = 8'h25;
  localparam logic [7:0] ADDR_GATE = 8'h26;
  localparam logic [7:0] ADDR_TURN = 8'h27;
  localparam logic [7:0] ADDR_HSL = 8'h28;
  localparam logic [7:0] ADDR_HSH = 8'h29;
  localparam logic [7:0] ADDR_SRST = 8'h2a;
  localparam logic [7:0] ADDR_CIPH = 8'h2c;
  localparam logic [7:0] ADDR_SETTLE = 8'h2e;

  localparam logic [7:0] RST_ALIGN = 8'h00;
  localparam logic [1:0] RST_AVG = 2'h3;
  localparam logic [3:0] RST_TURN = 4'h4;
  localparam logic [3:0] TURN_LOW_NIB = 4'h8;
  localparam logic [3:0] TURN_MIN = 4'h2;
  localparam logic [3:0] RST_SETTLE = 4'h7;
  localparam logic [3:0] RST_SIFS = 4'h5;
  localparam logic [2:0] RST_SUITE = 3'h0;

  // Field positions
  localparam int BIT_MASK = 7;
  localparam int BIT_CAUSE = 6;
  localparam int POS_AVG = 4;
  localparam int BIT_SLOT_QUEUE_CLOCK_ON = 3;
  localparam int POS_TURN = 4;
  localparam int BIT_PWR = 2;
  localparam int BIT_BB = 1;
  localparam int BIT_MAC = 0;
  localparam int BIT_SKIP = 7;
  localparam int BIT_GO = 6;
  localparam int POS_RXS = 3;
  localparam int POS_TXS = 0;

  // Timing: symbol 16 us, half-symbol tick 8 us
  localparam int CLK_NS = 10;
  localparam int SYMBOL_US = 16;
  localparam int HALF_SYM_US = 8;
  localparam int SYMBOL_CYC = SYMBOL_US * 1000 / CLK_NS;
  localparam int HALF_SYM_CYC = HALF_SYM_US * 1000 / CLK_NS;

  typedef struct packed {
    logic [1:0] retries;
    logic busy;
    logic short2;
    logic short1;
    logic fail2;
    logic fail1;
    logic failn;
  } mtxr_stat_s;

  typedef enum logic [1:0] {
    MTXR_Q_NORMAL = 2'b00,
    MTXR_Q_SLOT1 = 2'b01,
    MTXR_Q_SLOT2 = 2'b10
  } mtxr_queue_e;

  typedef struct packed {
    logic done;
    logic [1:0] queue;
    logic [1:0] retries;
    logic busy;
    logic short_time;
    logic retry_fail;
  } mtxr_txdone_s;

  typedef enum logic [1:0] {
    MTXR_AVG_1 = 2'b00,
    MTXR_AVG_2 = 2'b01,
    MTXR_AVG_4 = 2'b10,
    MTXR_AVG_8 = 2'b11
  } mtxr_avg_e;

endpackage : mtxr_pkg

// File: rtl/mtxr_regs.sv
`timescale 1ns/100ps
// What this block does
// R1: 8-bit RW superframe offset, reset zero, advised value 0x15.
// R2: Top two read-only status bits give retries of last normal transmission.
// R3: Channel busy flag one for busy, zero for idle on last transmission.
// R4: Per slot queue, flag one when slot time ran short, zero on success.
// R5: Release fail flags for slot two, slot one, normal queue; one on retry excess.
// R6: Beacon queue interrupt suppressed while mask bit one; mask resets zero.
// R7: Read-only wake cause bit: one beacon start, zero wake-up.
// R8: 2-bit averaging depth: 11=8, 10=4, 01=2, 00=1 symbols; reset 11.
// R9: Slot queue clock runs only while gate bit one; resets zero.
// R10: 4-bit turnaround in symbols, reset 0x4, never below 0x2.
// R11: Software makes turnaround plus settle total 12 symbols.
// R12: Software keeps turnaround register low nibble at 0x8.
// R13: 16-bit RW half-symbol timer in two bytes, 8 us unit, reset zero.
// R14: Writing one to power reset bit pulses reset, bit self-clears.
// R15: Writing one to baseband reset bit pulses reset, bit self-clears.
// R16: Writing one to MAC reset bit pulses reset, bit self-clears.
// R17: Write-only decrypt skip bit, one skips decryption of received frame.
// R18: Write-only decrypt start bit, one starts decryption of received frame.
// R19: 3-bit receive suite select, same coding, reset none.
// R20: 3-bit normal transmit suite in low bits, reset none.
// R21: Oscillator settle field in symbols, reset 0x7, advised 0x9.
// R22: Busy updates on each completed attempt, other status fields only on completions of their own queue; all hold until next.
module mtxr_regs (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire mtxr_pkg::mtxr_txdone_s tx_done,
  input wire logic wake_alert_irq,
  input wire logic wake_from_beacon,
  input wire logic beacon_tx_irq,
  output logic beacon_irq_out,
  output logic [7:0] superframe_align_reg,
  output mtxr_pkg::mtxr_avg_e signal_avg_depth,
  output logic slot_queue_clock_on,
  output logic [3:0] turnaround_symbols,
  output logic [3:0] osc_settle_period,
  output logic [15:0] half_symbol_count,
  output logic half_symbol_tick,
  output logic power_mgmt_reset,
  output logic baseband_reset,
  output logic mac_core_reset,
  output logic rx_decrypt_skip,
  output logic rx_decrypt_go,
  output logic [2:0] rx_suite_select,
  output logic [2:0] tx_normal_suite_select
);

  logic [7:0] align_q;
  mtxr_pkg::mtxr_stat_s stat_q;
  logic mask_q;
  logic cause_q;
  logic [1:0] avg_q;
  logic gts_q;
  logic [3:0] turn_q;
  logic [3:0] settle_q;
  logic [3:0] sifs_q;
  logic [15:0] hst_q;
  logic [2:0] srst_q;
  logic skip_q;
  logic go_q;
  logic [2:0] rxs_q;
  logic [2:0] txs_q;
  logic [7:0] rdata_q;
  logic birq_q;
  logic [9:0] tick_cnt_q;
  logic tick_q;

  ////////////////////////////////////////////////////////////////////////
  // Writable configuration

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      align_q <= mtxr_pkg::RST_ALIGN;
    end else if (reg_wr && reg_addr == mtxr_pkg::ADDR_ALIGN) begin
      align_q <= reg_wdata; // see R1
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      mask_q <= 1'b0;
      avg_q <= mtxr_pkg::RST_AVG;
    end else if (reg_wr && reg_addr == mtxr_pkg::ADDR_BCON) begin
      mask_q <= reg_wdata[mtxr_pkg::BIT_MASK]; // see R6
      avg_q <= reg_wdata[mtxr_pkg::POS_AVG +: 2]; // see R8
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      gts_q <= 1'b0;
    end else if (reg_wr && reg_addr == mtxr_pkg::ADDR_GATE) begin
      gts_q <= reg_wdata[mtxr_pkg::BIT_SLOT_QUEUE_CLOCK_ON]; // see R9
    end
  end

  // Values below the minimum are clamped up to it
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      turn_q <= mtxr_pkg::RST_TURN;
    end else if (reg_wr && reg_addr == mtxr_pkg::ADDR_TURN) begin
      if (reg_wdata[mtxr_pkg::POS_TURN +: 4] < mtxr_pkg::TURN_MIN) begin
        turn_q <= mtxr_pkg::TURN_MIN; // see R10
      end else begin
        turn_q <= reg_wdata[mtxr_pkg::POS_TURN +: 4]; // see R10
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      settle_q <= mtxr_pkg::RST_SETTLE;
      sifs_q <= mtxr_pkg::RST_SIFS;
    end else if (reg_wr && reg_addr == mtxr_pkg::ADDR_SETTLE) begin
      settle_q <= reg_wdata[7:4]; // see R21
      sifs_q <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      hst_q <= 16'h0000;
    end else if (reg_wr && reg_addr == mtxr_pkg::ADDR_HSL) begin
      hst_q[7:0] <= reg_wdata; // see R13
    end else if (reg_wr && reg_addr == mtxr_pkg::ADDR_HSH) begin
      hst_q[15:8] <= reg_wdata; // see R13
    end
  end

  // Free-running 8 us tick for the half-symbol timer consumer
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      tick_cnt_q <= 10'h000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == 10'(mtxr_pkg::HALF_SYM_CYC - 1)) begin
      tick_cnt_q <= 10'h000;
      tick_q <= 1'b1; // see R13
    end else begin
      tick_cnt_q <= tick_cnt_q + 10'h001;
      tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Self-clearing strobes: one cycle high per written one

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      srst_q <= 3'h0;
    end else if (reg_wr && reg_addr == mtxr_pkg::ADDR_SRST) begin
      srst_q <= reg_wdata[2:0]; // see R14 R15 R16
    end else begin
      srst_q <= 3'h0; // see R14 R15 R16
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      skip_q <= 1'b0;
      go_q <= 1'b0;
      rxs_q <= mtxr_pkg::RST_SUITE;
      txs_q <= mtxr_pkg::RST_SUITE;
    end else if (reg_wr && reg_addr == mtxr_pkg::ADDR_CIPH) begin
      skip_q <= reg_wdata[mtxr_pkg::BIT_SKIP]; // see R17
      go_q <= reg_wdata[mtxr_pkg::BIT_GO]; // see R18
      rxs_q <= reg_wdata[mtxr_pkg::POS_RXS +: 3]; // see R19
      txs_q <= reg_wdata[mtxr_pkg::POS_TXS +: 3]; // see R20
    end else begin
      skip_q <= 1'b0;
      go_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Hardware status

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      stat_q <= '0;
    end else if (tx_done.done) begin
      stat_q.busy <= tx_done.busy; // see R3 R22
      case (tx_done.queue)
        mtxr_pkg::MTXR_Q_NORMAL: begin
          stat_q.retries <= tx_done.retries; // see R2
          stat_q.failn <= tx_done.retry_fail; // see R5
        end
        mtxr_pkg::MTXR_Q_SLOT1: begin
          stat_q.short1 <= tx_done.short_time; // see R4
          stat_q.fail1 <= tx_done.retry_fail; // see R5
        end
        mtxr_pkg::MTXR_Q_SLOT2: begin
          stat_q.short2 <= tx_done.short_time; // see R4
          stat_q.fail2 <= tx_done.retry_fail; // see R5
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cause_q <= 1'b0;
    end else if (wake_alert_irq) begin
      cause_q <= wake_from_beacon; // see R7
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      birq_q <= 1'b0;
    end else begin
      birq_q <= beacon_tx_irq && !mask_q; // see R6
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        mtxr_pkg::ADDR_ALIGN: rdata_q <= align_q;
        mtxr_pkg::ADDR_TXRES: rdata_q <= stat_q;
        mtxr_pkg::ADDR_BCON: rdata_q <= {mask_q, cause_q, avg_q, 4'h0};
        mtxr_pkg::ADDR_GATE: rdata_q <= {4'h0, gts_q, 3'h0};
        mtxr_pkg::ADDR_TURN: rdata_q <= {turn_q, mtxr_pkg::TURN_LOW_NIB}; // see R12
        mtxr_pkg::ADDR_HSL: rdata_q <= hst_q[7:0];
        mtxr_pkg::ADDR_HSH: rdata_q <= hst_q[15:8];
        mtxr_pkg::ADDR_SRST: rdata_q <= 8'h00;
        mtxr_pkg::ADDR_CIPH: rdata_q <= {2'h0, rxs_q, txs_q};
        mtxr_pkg::ADDR_SETTLE: rdata_q <= {settle_q, sifs_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;
  assign beacon_irq_out = birq_q;
  assign superframe_align_reg = align_q;
  assign signal_avg_depth = mtxr_pkg::mtxr_avg_e'(avg_q);
  assign slot_queue_clock_on = gts_q;
  assign turnaround_symbols = turn_q;
  assign osc_settle_period = settle_q;
  assign half_symbol_count = hst_q;
  assign half_symbol_tick = tick_q;
  assign power_mgmt_reset = srst_q[mtxr_pkg::BIT_PWR];
  assign baseband_reset = srst_q[mtxr_pkg::BIT_BB];
  assign mac_core_reset = srst_q[mtxr_pkg::BIT_MAC];
  assign rx_decrypt_skip = skip_q;
  assign rx_decrypt_go = go_q;
  assign rx_suite_select = rxs_q;
  assign tx_normal_suite_select = txs_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  align_write_a: assert property (reg_wr && reg_addr == mtxr_pkg::ADDR_ALIGN // see R1
      |=> superframe_align_reg == $past(reg_wdata))
    else $error("align offset not stored");
  retry_hold_a: assert property (!tx_done.done |=> $stable(stat_q)) // see R22
    else $error("status changed without completion");
  normal_retry_a: assert property (tx_done.done && tx_done.queue == 2'b00 // see R2
      |=> stat_q.retries == $past(tx_done.retries) && stat_q.failn == $past(tx_done.retry_fail))
    else $error("normal queue status wrong");
  busy_flag_a: assert property (tx_done.done |=> stat_q.busy == $past(tx_done.busy)) // see R3
    else $error("busy flag wrong");
  slot_short_a: assert property (tx_done.done && tx_done.queue == 2'b10 // see R4
      |=> stat_q.short2 == $past(tx_done.short_time) && stat_q.fail2 == $past(tx_done.retry_fail))
    else $error("slot two status wrong");
  beacon_mask_a: assert property (mask_q |=> !beacon_irq_out) // see R6
    else $error("masked beacon interrupt leaked");
  turn_floor_a: assert property (turnaround_symbols >= mtxr_pkg::TURN_MIN) // see R10
    else $error("turnaround below minimum");
  srst_pulse_a: assert property (!(reg_wr && reg_addr == mtxr_pkg::ADDR_SRST) // see R14
      |=> !power_mgmt_reset)
    else $error("power reset did not clear");
  bb_pulse_a: assert property (reg_wr && reg_addr == mtxr_pkg::ADDR_SRST && reg_wdata[1] // see R15
      ##1 !(reg_wr && reg_addr == mtxr_pkg::ADDR_SRST)
      |-> baseband_reset ##1 !baseband_reset)
    else $error("baseband reset pulse wrong");
  mac_pulse_a: assert property (reg_wr && reg_addr == mtxr_pkg::ADDR_SRST && reg_wdata[0] // see R16
      ##1 !(reg_wr && reg_addr == mtxr_pkg::ADDR_SRST)
      |-> mac_core_reset ##1 !mac_core_reset)
    else $error("mac reset pulse wrong");
  decrypt_go_a: assert property (rx_decrypt_go || rx_decrypt_skip // see R18
      |-> $past(reg_wr) && $past(reg_addr) == mtxr_pkg::ADDR_CIPH)
    else $error("decrypt strobe without write");
  read_delay_a: assert property (reg_rd && reg_addr == mtxr_pkg::ADDR_HSH // see R13
      && !reg_wr |=> reg_rdata == half_symbol_count[15:8])
    else $error("timer high byte read wrong");

  srst_cov_c: cover property (reg_wr && reg_addr == mtxr_pkg::ADDR_SRST ##1 mac_core_reset);
  fail_cov_c: cover property (tx_done.done && tx_done.retry_fail);
  mask_cov_c: cover property (beacon_tx_irq && mask_q);

endmodule : mtxr_regs

// File: testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  mtxr_pkg::mtxr_txdone_s tx_done = '0;
  logic wake_alert_irq = 1'b0;
  logic wake_from_beacon = 1'b0;
  logic beacon_tx_irq = 1'b0;
  logic beacon_irq_out;
  logic [7:0] superframe_align_reg;
  mtxr_pkg::mtxr_avg_e signal_avg_depth;
  logic slot_queue_clock_on;
  logic [3:0] turnaround_symbols;
  logic [3:0] osc_settle_period;
  logic [15:0] half_symbol_count;
  logic half_symbol_tick;
  logic power_mgmt_reset;
  logic baseband_reset;
  logic mac_core_reset;
  logic rx_decrypt_skip;
  logic rx_decrypt_go;
  logic [2:0] rx_suite_select;
  logic [2:0] tx_normal_suite_select;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;

  mtxr_regs dut_u (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .tx_done, .wake_alert_irq, .wake_from_beacon, .beacon_tx_irq, .beacon_irq_out,
    .superframe_align_reg, .signal_avg_depth, .slot_queue_clock_on, .turnaround_symbols,
    .osc_settle_period, .half_symbol_count, .half_symbol_tick, .power_mgmt_reset,
    .baseband_reset, .mac_core_reset, .rx_decrypt_skip, .rx_decrypt_go, .rx_suite_select,
    .tx_normal_suite_select);

  always #5 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  // Hang guard, well above the roughly 1800 cycles the scenarios need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask : rd_chk

  task automatic send_done(input logic [1:0] q, input logic [1:0] r, input logic b,
                           input logic s, input logic f);
    @(posedge mclk);
    tx_done <= {1'b1, q, r, b, s, f};
    @(posedge mclk);
    tx_done <= '0;
  endtask : send_done

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_chk(8'h23, 8'h00);
    rd_chk(8'h25, 8'h30);
    rd_chk(8'h26, 8'h00);
    rd_chk(8'h27, 8'h48);
    rd_chk(8'h28, 8'h00);
    rd_chk(8'h29, 8'h00);
    rd_chk(8'h2c, 8'h00);
    rd_chk(8'h2e, 8'h75);
    chk({12'h0, signal_avg_depth, turnaround_symbols[1:0]}, 16'h000c);
    chk({8'h0, turnaround_symbols, osc_settle_period}, 16'h0047);
    chk({10'h0, rx_suite_select, tx_normal_suite_select}, 16'h0000);
  endtask : t_reset

  task automatic t_rw;
    wr(8'h23, 8'h15);
    chk({8'h0, superframe_align_reg}, 16'h0015);
    rd_chk(8'h23, 8'h15);
    wr(8'h28, 8'ha5);
    wr(8'h29, 8'h3c);
    chk(half_symbol_count, 16'h3ca5);
    rd_chk(8'h28, 8'ha5);
    rd_chk(8'h29, 8'h3c);
    wr(8'h26, 8'h08);
    chk({15'h0, slot_queue_clock_on}, 16'h0001);
    rd_chk(8'h26, 8'h08);
    wr(8'h26, 8'h00);
    chk({15'h0, slot_queue_clock_on}, 16'h0000);
    wr(8'h2b, 8'hff);
    rd_chk(8'h2b, 8'h00);
    rd_chk(8'h22, 8'h00);
  endtask : t_rw

  task automatic t_avg;
    for (int i = 0; i < 4; i++) begin
      wr(8'h25, {2'b00, 2'(i), 4'h0});
      chk({14'h0, signal_avg_depth}, 16'(i));
      rd_chk(8'h25, {2'b00, 2'(i), 4'h0});
    end
  endtask : t_avg

  task automatic t_turn;
    wr(8'h27, 8'h38);
    wr(8'h2e, 8'h95);
    chk({8'h0, turnaround_symbols, osc_settle_period}, 16'h0039);
    rd_chk(8'h27, 8'h38);
    rd_chk(8'h2e, 8'h95);
    wr(8'h27, 8'h18);
    chk({12'h0, turnaround_symbols}, 16'h0002);
    rd_chk(8'h27, 8'h28);
  endtask : t_turn

  task automatic t_srst;
    for (int b = 0; b < 3; b++) begin
      wr(8'h2a, 8'h01 << b);
      chk({13'h0, power_mgmt_reset, baseband_reset, mac_core_reset}, 16'h1 << b);
      @(posedge mclk);
      #1;
      chk({13'h0, power_mgmt_reset, baseband_reset, mac_core_reset}, 16'h0);
      rd_chk(8'h2a, 8'h00);
    end
  endtask : t_srst

  task automatic t_cipher;
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      wr(8'h2c, {c[0], ~c[0], c, ~c});
      chk({14'h0, rx_decrypt_skip, rx_decrypt_go}, {14'h0, c[0], ~c[0]});
      chk({10'h0, rx_suite_select, tx_normal_suite_select}, {10'h0, c, ~c});
      @(posedge mclk);
      #1;
      chk({14'h0, rx_decrypt_skip, rx_decrypt_go}, 16'h0);
      rd_chk(8'h2c, {2'b00, c, ~c});
    end
  endtask : t_cipher

  task automatic t_status;
    send_done(2'd0, 2'd2, 1'b1, 1'b0, 1'b1);
    rd_chk(8'h24, 8'ha1);
    send_done(2'd1, 2'd0, 1'b0, 1'b1, 1'b1);
    rd_chk(8'h24, 8'h8b);
    send_done(2'd2, 2'd1, 1'b1, 1'b1, 1'b0);
    rd_chk(8'h24, 8'hbb);
    send_done(2'd0, 2'd0, 1'b0, 1'b0, 1'b0);
    rd_chk(8'h24, 8'h1a);
    send_done(2'd3, 2'd3, 1'b1, 1'b1, 1'b1);
    rd_chk(8'h24, 8'h3a);
    wr(8'h24, 8'hff);
    repeat (20) @(posedge mclk);
    rd_chk(8'h24, 8'h3a);
  endtask : t_status

  task automatic t_beacon;
    wr(8'h25, 8'h30);
    @(posedge mclk);
    beacon_tx_irq <= 1'b1;
    @(posedge mclk);
    #1;
    chk({15'h0, beacon_irq_out}, 16'h0001);
    wr(8'h25, 8'hb0);
    @(posedge mclk);
    #1;
    chk({15'h0, beacon_irq_out}, 16'h0000);
    @(posedge mclk);
    beacon_tx_irq <= 1'b0;
    for (int k = 1; k >= 0; k--) begin
      @(posedge mclk);
      wake_alert_irq <= 1'b1;
      wake_from_beacon <= 1'(k);
      @(posedge mclk);
      wake_alert_irq <= 1'b0;
      wake_from_beacon <= 1'(~k);
      rd_chk(8'h25, {1'b1, 1'(k), 6'h30});
    end
    wr(8'h25, 8'h70);
    rd_chk(8'h25, 8'h30);
  endtask : t_beacon

  task automatic t_tick;
    int n;
    n = 0;
    repeat (1600) begin
      @(posedge mclk);
      #1;
      n += int'(half_symbol_tick);
    end
    chk(16'(n), 16'd2);
  endtask : t_tick

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_rw();
    t_avg();
    t_turn();
    t_srst();
    t_cipher();
    t_status();
    t_beacon();
    t_tick();
    end_of_test();
  end
endmodule : tb_top
